// *** include/dtc_cfg.svh ***
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
`define DTC_ADDR_CTRL      8'h88
`define DTC_ADDR_MODE      8'h89
`define DTC_ADDR_U0_LOW    8'h8a
`define DTC_ADDR_U1_LOW    8'h8b
`define DTC_ADDR_U0_HIGH   8'h8c
`define DTC_ADDR_U1_HIGH   8'h8d
`define DTC_ADDR_IRQ_STAT  8'h90
`define DTC_ADDR_IRQ_MASK  8'h91
`define DTC_ADDR_ACK       8'h92
`define DTC_CTRL_U1_OVF    7
`define DTC_CTRL_U1_RUN    6
`define DTC_CTRL_U0_OVF    5
`define DTC_CTRL_U0_RUN    4
`define DTC_CTRL_X1_PEND   3
`define DTC_CTRL_X1_TYPE   2
`define DTC_CTRL_X0_PEND   1
`define DTC_CTRL_X0_TYPE   0
`define DTC_MODE_U1_GATE   7
`define DTC_MODE_U1_SRC    6
`define DTC_MODE_U0_GATE   3
`define DTC_MODE_U0_SRC    2
`define DTC_RESET_BYTE     8'h00
`define DTC_PER_CLK_DIV    6
`define DTC_PRESCALE_MASK  8'h1f
`endif

// *** include/dtc_pkg.sv ***
package dtc_pkg;
    typedef logic [7:0] dtc_byte_t;
    typedef enum logic [1:0] {
        DTC_MODE_13BIT  = 2'b00,
        DTC_MODE_16BIT  = 2'b01,
        DTC_MODE_RELOAD = 2'b10,
        DTC_MODE_SPLIT  = 2'b11
    } dtc_mode_t;
endpackage

// *** verilog/dtc_unit.sv ***
`include "dtc_cfg.svh"
// One count unit: low/high bytes plus its count step, no registers of its own
module dtc_unit
    import dtc_pkg::*;
(
    // Configuration
    input  wire logic          split_i,
    input  dtc_pkg::dtc_mode_t mode_i,
    // Count enables
    input  wire logic          low_step_i,
    input  wire logic          high_step_i,
    // Current count
    input  dtc_pkg::dtc_byte_t low_i,
    input  dtc_pkg::dtc_byte_t high_i,
    // Next count
    output dtc_pkg::dtc_byte_t low_o,
    output dtc_pkg::dtc_byte_t high_o,
    output logic               low_ovf_o,
    output logic               high_ovf_o
);
    always_comb begin
        low_o      = low_i;
        high_o     = high_i;
        low_ovf_o  = 1'b0;
        high_ovf_o = 1'b0;
        case (mode_i)
            DTC_MODE_13BIT: begin
                if (low_step_i) begin
                    // Upper three prescaler bits are left as they are
                    low_o = (low_i & ~`DTC_PRESCALE_MASK) | ((low_i + 8'h01) & `DTC_PRESCALE_MASK);
                    if ((low_i & `DTC_PRESCALE_MASK) == `DTC_PRESCALE_MASK) begin
                        high_o     = high_i + 8'h01;
                        high_ovf_o = (high_i == 8'hff);
                    end
                end
            end
            DTC_MODE_16BIT: begin
                if (low_step_i) begin
                    low_o = low_i + 8'h01;
                    if (low_i == 8'hff) begin
                        high_o     = high_i + 8'h01;
                        high_ovf_o = (high_i == 8'hff);
                    end
                end
            end
            DTC_MODE_RELOAD: begin
                if (low_step_i) begin
                    if (low_i == 8'hff) begin
                        low_o      = high_i;
                        high_ovf_o = 1'b1;
                    end else begin
                        low_o = low_i + 8'h01;
                    end
                end
            end
            DTC_MODE_SPLIT: begin
                if (split_i) begin
                    if (low_step_i) begin
                        low_o     = low_i + 8'h01;
                        low_ovf_o = (low_i == 8'hff);
                    end
                    if (high_step_i) begin
                        high_o     = high_i + 8'h01;
                        high_ovf_o = (high_i == 8'hff);
                    end
                end
                // Otherwise hold the count
            end
            default: begin
                low_o = low_i;
            end
        endcase
    end
endmodule

// *** verilog/dtc_top.sv ***
`include "dtc_cfg.svh"
module dtc_top
    import dtc_pkg::*;
#(
    parameter int DIV = `DTC_PER_CLK_DIV
)(
    // Clock and reset
    input  wire logic          mclk_i,
    input  wire logic          reset_i,
    // Register port
    input  wire logic [7:0]    addr_i,
    input  dtc_pkg::dtc_byte_t wdata_i,
    input  wire logic          wr_i,
    input  wire logic          rd_i,
    output dtc_pkg::dtc_byte_t rdata_o,
    // Pins
    input  wire logic          ext_irq0_pin_i,
    input  wire logic          ext_irq1_pin_i,
    input  wire logic          unit0_count_pin_i,
    input  wire logic          unit1_count_pin_i,
    // Interrupt service acknowledges
    input  wire logic          unit0_ovf_ack_i,
    input  wire logic          unit1_ovf_ack_i,
    input  wire logic          ext_irq0_ack_i,
    input  wire logic          ext_irq1_ack_i,
    // Interrupt
    output logic               irq_o
);
    import dtc_pkg::*;

    typedef struct packed {
        dtc_byte_t   ctrl;
        dtc_byte_t   mode;
        dtc_byte_t   u0_low;
        dtc_byte_t   u0_high;
        dtc_byte_t   u1_low;
        dtc_byte_t   u1_high;
        logic [5:0]  stat;
        logic [5:0]  mask;
        logic [2:0]  div_cnt;
        logic [1:0]  cnt_smp;
        logic [1:0]  irq_smp;
        dtc_byte_t   rdata;
        logic        irq;
    } dtc_state_t;

    dtc_state_t st_r;
    dtc_state_t st_nxt;

    dtc_mode_t  u0_mode;
    dtc_mode_t  u1_mode;
    logic       per_tick;
    logic       u0_step;
    logic       u1_step;
    logic       u0_hstep;
    logic       u0_split;
    dtc_byte_t  u0_low_n;
    dtc_byte_t  u0_high_n;
    dtc_byte_t  u1_low_n;
    dtc_byte_t  u1_high_n;
    logic       u0_lovf;
    logic       u0_hovf;
    logic       u1_lovf;
    logic       u1_hovf;

    // Pick the count event: divided clock or a sampled falling pin edge
    function automatic logic count_event(input logic src, input logic tick, input logic prev, input logic pin);
        count_event = src ? (tick & prev & ~pin) : tick;
    endfunction

    function automatic logic unit_enabled(input logic run, input logic gate, input logic irq_pin);
        unit_enabled = run & (~gate | irq_pin);
    endfunction

    assign u0_mode  = dtc_mode_t'(st_r.mode[1:0]);
    assign u1_mode  = dtc_mode_t'(st_r.mode[5:4]);
    assign u0_split = (u0_mode == DTC_MODE_SPLIT);
    assign per_tick = (st_r.div_cnt == 3'(DIV - 1));

    // Count pins are sampled once per peripheral cycle; the gate pins are used directly
    assign u0_step = unit_enabled(st_r.ctrl[`DTC_CTRL_U0_RUN], st_r.mode[`DTC_MODE_U0_GATE], ext_irq0_pin_i) &
                     count_event(st_r.mode[`DTC_MODE_U0_SRC], per_tick, st_r.cnt_smp[0], unit0_count_pin_i);
    // Split mode takes unit-1 run away from unit 1
    assign u1_step = unit_enabled(st_r.ctrl[`DTC_CTRL_U1_RUN] & ~u0_split, st_r.mode[`DTC_MODE_U1_GATE],
                                  ext_irq1_pin_i) &
                     count_event(st_r.mode[`DTC_MODE_U1_SRC], per_tick, st_r.cnt_smp[1], unit1_count_pin_i);
    assign u0_hstep = st_r.ctrl[`DTC_CTRL_U1_RUN] & per_tick;

    dtc_unit u_unit0 (
        .split_i     (1'b1),
        .mode_i      (u0_mode),
        .low_step_i  (u0_step),
        .high_step_i (u0_hstep),
        .low_i       (st_r.u0_low),
        .high_i      (st_r.u0_high),
        .low_o       (u0_low_n),
        .high_o      (u0_high_n),
        .low_ovf_o   (u0_lovf),
        .high_ovf_o  (u0_hovf)
    );

    // Mode 11 on unit 1 means hold, so split is off
    dtc_unit u_unit1 (
        .split_i     (1'b0),
        .mode_i      (u1_mode),
        .low_step_i  (u1_step),
        .high_step_i (1'b0),
        .low_i       (st_r.u1_low),
        .high_i      (st_r.u1_high),
        .low_o       (u1_low_n),
        .high_o      (u1_high_n),
        .low_ovf_o   (u1_lovf),
        .high_ovf_o  (u1_hovf)
    );

    always_comb begin
        logic       ovf0;
        logic       ovf1;
        logic       x0_set;
        logic       x1_set;
        logic [5:0] ev;
        ovf0   = 1'b0;
        ovf1   = 1'b0;
        x0_set = 1'b0;
        x1_set = 1'b0;
        ev     = 6'h00;
        st_nxt = st_r;

        st_nxt.div_cnt = per_tick ? 3'h0 : st_r.div_cnt + 3'h1;
        if (per_tick) begin
            st_nxt.cnt_smp = {unit1_count_pin_i, unit0_count_pin_i};
            st_nxt.irq_smp = {ext_irq1_pin_i, ext_irq0_pin_i};
        end

        // Register writes; software stops a unit before preloading
        if (wr_i) begin
            case (addr_i)
                `DTC_ADDR_CTRL:     st_nxt.ctrl    = wdata_i;
                `DTC_ADDR_MODE:     st_nxt.mode    = wdata_i;
                `DTC_ADDR_U0_LOW:   st_nxt.u0_low  = wdata_i;
                `DTC_ADDR_U0_HIGH:  st_nxt.u0_high = wdata_i;
                `DTC_ADDR_U1_LOW:   st_nxt.u1_low  = wdata_i;
                `DTC_ADDR_U1_HIGH:  st_nxt.u1_high = wdata_i;
                `DTC_ADDR_IRQ_STAT: st_nxt.stat    = st_r.stat & ~wdata_i[5:0];
                `DTC_ADDR_IRQ_MASK: st_nxt.mask    = wdata_i[5:0];
                default:            st_nxt.mask    = st_r.mask;
            endcase
        end

        // Counting; a byte write in the same cycle wins
        if (!(wr_i && addr_i == `DTC_ADDR_U0_LOW))
            st_nxt.u0_low = u0_low_n;
        if (!(wr_i && addr_i == `DTC_ADDR_U0_HIGH))
            st_nxt.u0_high = u0_high_n;
        if (!(wr_i && addr_i == `DTC_ADDR_U1_LOW))
            st_nxt.u1_low = u1_low_n;
        if (!(wr_i && addr_i == `DTC_ADDR_U1_HIGH))
            st_nxt.u1_high = u1_high_n;

        ovf0 = u0_split ? u0_lovf : u0_hovf;
        ovf1 = (u0_split & u0_hovf) | u1_hovf;

        // External pins: low level or sampled falling edge
        x0_set = st_r.ctrl[`DTC_CTRL_X0_TYPE] ? (per_tick & st_r.irq_smp[0] & ~ext_irq0_pin_i)
                                              : ~ext_irq0_pin_i;
        x1_set = st_r.ctrl[`DTC_CTRL_X1_TYPE] ? (per_tick & st_r.irq_smp[1] & ~ext_irq1_pin_i)
                                              : ~ext_irq1_pin_i;

        // Acks clear (external pends only in edge mode), but a new event in the same cycle wins
        if (unit1_ovf_ack_i)
            st_nxt.ctrl[`DTC_CTRL_U1_OVF] = 1'b0;
        if (unit0_ovf_ack_i)
            st_nxt.ctrl[`DTC_CTRL_U0_OVF] = 1'b0;
        if (ext_irq1_ack_i && st_r.ctrl[`DTC_CTRL_X1_TYPE])
            st_nxt.ctrl[`DTC_CTRL_X1_PEND] = 1'b0;
        if (ext_irq0_ack_i && st_r.ctrl[`DTC_CTRL_X0_TYPE])
            st_nxt.ctrl[`DTC_CTRL_X0_PEND] = 1'b0;
        if (ovf1)
            st_nxt.ctrl[`DTC_CTRL_U1_OVF] = 1'b1;
        if (ovf0)
            st_nxt.ctrl[`DTC_CTRL_U0_OVF] = 1'b1;
        if (x1_set)
            st_nxt.ctrl[`DTC_CTRL_X1_PEND] = 1'b1;
        if (x0_set)
            st_nxt.ctrl[`DTC_CTRL_X0_PEND] = 1'b1;

        // Sticky status: ovf0, ovf1, x0, x1, u0 low-ovf in split, u1 low wrap
        ev = {u1_lovf | (u1_step && st_r.u1_low == 8'hff), u0_lovf, x1_set, x0_set, ovf1, ovf0};
        st_nxt.stat = st_nxt.stat | ev;
        st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);

        st_nxt.rdata = 8'h00;
        if (rd_i) begin
            case (addr_i)
                `DTC_ADDR_CTRL:     st_nxt.rdata = st_r.ctrl;
                `DTC_ADDR_MODE:     st_nxt.rdata = st_r.mode;
                `DTC_ADDR_U0_LOW:   st_nxt.rdata = st_r.u0_low;
                `DTC_ADDR_U0_HIGH:  st_nxt.rdata = st_r.u0_high;
                `DTC_ADDR_U1_LOW:   st_nxt.rdata = st_r.u1_low;
                `DTC_ADDR_U1_HIGH:  st_nxt.rdata = st_r.u1_high;
                `DTC_ADDR_IRQ_STAT: st_nxt.rdata = {2'h0, st_r.stat};
                `DTC_ADDR_IRQ_MASK: st_nxt.rdata = {2'h0, st_r.mask};
                default:            st_nxt.rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign rdata_o = st_r.rdata;
    assign irq_o   = st_r.irq;
endmodule

// *** bench/dtc_pins_model.sv ***
module dtc_pins_model #(
    parameter int HOLD = 8
)(
    input  wire logic       clk_i,
    input  wire logic       reset_i,
    input  wire logic [1:0] pulse_i,
    output logic      [1:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    int cnt [2];
    // Low then high, each longer than one sample period so neither is missed
    always @(posedge clk_i or posedge reset_i) begin
        for (int i = 0; i < 2; i++) begin
            if (reset_i) begin
                cnt[i] <= 0;
            end else if (pulse_i[i] && cnt[i] == 0) begin
                cnt[i] <= 2 * HOLD;
            end else if (cnt[i] != 0) begin
                cnt[i] <= cnt[i] - 1;
            end
        end
    end
    assign pin_o = {cnt[1] <= HOLD, cnt[0] <= HOLD};
endmodule

// *** bench/dtc_checker.sv ***
module dtc_checker
    import dtc_pkg::*;
(
    input wire logic          mclk_i,
    input wire logic          reset_i,
    input wire logic [7:0]    addr_i,
    input dtc_pkg::dtc_byte_t wdata_i,
    input wire logic          wr_i,
    input wire logic          rd_i,
    input dtc_pkg::dtc_byte_t rdata_o,
    input wire logic          ext_irq0_pin_i,
    input wire logic          ext_irq1_pin_i,
    input wire logic          irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    logic       seen_r;
    logic [1:0] type_r;
    logic [1:0] low0_r;
    logic [1:0] low1_r;
    wire logic  cw = wr_i && addr_i == 8'h88;
    // A control write rewrites the flags, so low-pin runs restart there
    always_ff @(posedge mclk_i or posedge reset_i) begin
        if (reset_i) begin
            seen_r <= 1'b0;
            type_r <= 2'b00;
            low0_r <= 2'd0;
            low1_r <= 2'd0;
        end else begin
            seen_r <= seen_r | (wr_i && addr_i == 8'h91 && wdata_i != 8'h00);
            type_r <= cw ? {wdata_i[2], wdata_i[0]} : type_r;
            low0_r <= (ext_irq0_pin_i || cw) ? 2'd0 : low0_r + {1'b0, low0_r != 2'd3};
            low1_r <= (ext_irq1_pin_i || cw) ? 2'd0 : low1_r + {1'b0, low1_r != 2'd3};
        end
    end
    a_rdata_idle: assert property (!$past(rd_i) |-> rdata_o == 8'h00) else $error("stray read data");
    a_unmapped_zero: assert property (rd_i && addr_i == 8'h80 |=> rdata_o == 8'h00) else $error("hole read");
    a_mode_readback: assert property (wr_i && addr_i == 8'h89 ##2 rd_i && addr_i == 8'h89
        |=> rdata_o == $past(wdata_i, 3)) else $error("mode readback");
    a_ctrl_readback: assert property (cw ##2 rd_i && addr_i == 8'h88
        |=> (rdata_o & 8'h55) == ($past(wdata_i, 3) & 8'h55)) else $error("control readback");
    a_irq_unmasked: assert property (!seen_r |-> !irq_o) else $error("irq with zero mask");
    a_irq_mask_off: assert property (wr_i && addr_i == 8'h91 && wdata_i == 8'h00 |-> ##[1:2] !irq_o)
        else $error("irq after mask clear");
    a_level_pend0: assert property (rd_i && addr_i == 8'h88 && !type_r[0] && low0_r == 2'd3
        |=> rdata_o[1]) else $error("level pending 0");
    a_level_pend1: assert property (rd_i && addr_i == 8'h88 && !type_r[1] && low1_r == 2'd3
        |=> rdata_o[3]) else $error("level pending 1");
    c_irq: cover property ($rose(irq_o));
    c_back: cover property (wr_i ##2 rd_i);
    c_level: cover property (low0_r == 2'd3 && rd_i);
endmodule

// *** bench/testbench.sv ***
module testbench;
    import dtc_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int DIV = 6;
    localparam int HOLD = DIV + 2;
    logic        mclk_i = 1'b0;
    logic        reset_i = 1'b1;
    logic        wr_i = 1'b0;
    logic        rd_i = 1'b0;
    logic [7:0]  addr_i = 8'h00;
    dtc_byte_t   wdata_i = 8'h00;
    dtc_byte_t   rdata_o;
    dtc_byte_t   rq;
    logic [1:0]  xpin = 2'b11;
    logic [3:0]  ack = 4'h0;
    logic [1:0]  pulse = 2'b00;
    logic [1:0]  cpin;
    logic        irq_o;
    logic [15:0] v;
    logic [19:0] e;
    logic [7:0]  lo;
    int          fail_count = 0;
    int          n_tests = 0;
    int          cyc = 0;
    int          k;
    integer      seed = 32'h8d23001c;
    always #50 mclk_i = ~mclk_i;
    dtc_top #(.DIV(DIV)) i_dut (.mclk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
        .ext_irq0_pin_i(xpin[0]), .ext_irq1_pin_i(xpin[1]), .unit0_count_pin_i(cpin[0]),
        .unit1_count_pin_i(cpin[1]), .unit0_ovf_ack_i(ack[0]), .unit1_ovf_ack_i(ack[1]),
        .ext_irq0_ack_i(ack[2]), .ext_irq1_ack_i(ack[3]), .irq_o);
    dtc_pins_model #(.HOLD(HOLD)) i_pins (.clk_i(mclk_i), .reset_i, .pulse_i(pulse), .pin_o(cpin));
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [7:0] s, input logic [7:0] x);
        n_tests++;
        if (s !== x) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, x, s);
        end
    endtask
    // One idle edge after each transfer, so no strobe is driven twice in one step
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        wr_i <= w;
        rd_i <= !w;
        addr_i <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
        rd_i <= 1'b0;
        @(posedge mclk_i);
        // Read data stands in the cycle after the strobe edge
        if (!w) rq = rdata_o;
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [7:0] x);
        bus(1'b0, a, 8'h00);
        chk($sformatf("reg %h", a), rq, x);
    endtask
    task automatic pulse_ack(input logic [3:0] p);
        ack <= p;
        @(posedge mclk_i);
        ack <= 4'h0;
    endtask
    // At most one wrap per field within these short runs, except the mode 2 low byte, which can reload again on every step
    // Returns unit-1 low wrap, split low overflow, both flags, then the count
    function automatic logic [19:0] step(input logic u, input logic [1:0] m, input logic [15:0] x, input int n);
        logic [1:0] f;
        logic       w;
        f = 2'b00;
        w = 1'b0;
        for (int i = 0; i < n; i++) begin
            w = w | (u && m != 2'd3 && x[7:0] == 8'hff);
            case (m)
                2'd0: {f[u], x[15:8], x[4:0]} = {f[u], x[15:8], x[4:0]} + 14'd1;
                2'd1: {f[u], x} = {f[u], x} + 17'd1;
                2'd2: {f[u], x[7:0]} = x[7:0] == 8'hff ? {1'b1, x[15:8]} : {f[u], x[7:0] + 8'd1};
                default: if (!u) {f[1], x[15:8], f[0], x[7:0]} = {f[1], x[15:8], f[0], x[7:0]} + 18'h00201;
            endcase
        end
        return {w, f[0] & !u & (m == 2'd3), f[1], f[0], x};
    endfunction
    always @(posedge mclk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end
    initial begin
        repeat (12) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
        for (int a = 8'h88; a < 8'h8e; a++) rdchk(8'(a), 8'h00);
        bus(1'b1, 8'h80, 8'h5a);
        rdchk(8'h80, 8'h00);
        v = 16'($random(seed));
        bus(1'b1, 8'h89, v[7:0]);
        rdchk(8'h89, v[7:0]);
        bus(1'b1, 8'h91, 8'h03);
        for (int t = 0; t < 16; t++) begin
            v = 16'($random(seed)) | (t[3] ? 16'hffe8 : 16'h0000);
            k = 1 + int'($unsigned($random(seed)) % 40);
            lo = t[0] ? 8'h8b : 8'h8a;
            bus(1'b1, 8'h89, t[0] ? {2'b00, t[2:1], 4'h0} : {6'b001100, t[2:1]});
            bus(1'b1, lo, v[7:0]);
            bus(1'b1, lo + 8'h02, v[15:8]);
            bus(1'b1, 8'h90, 8'hff);
            bus(1'b1, 8'h88, t[0] ? 8'h45 : (t[2:1] == 2'd3 ? 8'h55 : 8'h15));
            repeat (k * DIV - 2) @(posedge mclk_i);
            bus(1'b1, 8'h88, 8'h05);
            e = step(t[0], t[2:1], v, k);
            rdchk(lo, e[7:0]);
            rdchk(lo + 8'h02, e[15:8]);
            rdchk(8'h90, {2'b00, e[19:18], 2'b00, e[17:16]});
            chk("irq", {7'h00, irq_o}, {7'h00, |e[17:16]});
        end
        bus(1'b1, 8'h89, 8'h22);
        for (int a = 8'h8a; a < 8'h8e; a++) bus(1'b1, 8'(a), a < 8'h8c ? 8'hfe : 8'h00);
        bus(1'b1, 8'h88, 8'h55);
        rdchk(8'h88, 8'h55);
        repeat (3 * DIV) @(posedge mclk_i);
        rdchk(8'h88, 8'hf5);
        pulse_ack(4'h3);
        rdchk(8'h88, 8'h55);
        bus(1'b1, 8'h88, 8'h05);
        bus(1'b1, 8'h89, 8'h55);
        bus(1'b1, 8'h8a, 8'h00);
        bus(1'b1, 8'h8b, 8'h00);
        bus(1'b1, 8'h88, 8'h55);
        k = 1 + int'($unsigned($random(seed)) % 5);
        repeat (k) begin
            pulse <= 2'b11;
            @(posedge mclk_i);
            pulse <= 2'b00;
            repeat (2 * HOLD + 2) @(posedge mclk_i);
        end
        bus(1'b1, 8'h88, 8'h05);
        rdchk(8'h8a, 8'(k));
        rdchk(8'h8b, 8'(k));
        xpin <= 2'b00;
        repeat (3 * DIV) @(posedge mclk_i);
        rdchk(8'h88, 8'h0f);
        pulse_ack(4'hc);
        rdchk(8'h88, 8'h05);
        bus(1'b1, 8'h88, 8'h00);
        pulse_ack(4'hc);
        repeat (3) @(posedge mclk_i);
        rdchk(8'h88, 8'h0a);
        bus(1'b1, 8'h89, 8'h99);
        bus(1'b1, 8'h88, 8'h50);
        repeat (4 * DIV) @(posedge mclk_i);
        bus(1'b1, 8'h88, 8'h00);
        rdchk(8'h8a, 8'(k));
        rdchk(8'h8b, 8'(k));
        bus(1'b1, 8'h91, 8'h0c);
        repeat (3) @(posedge mclk_i);
        chk("irq", {7'h00, irq_o}, 8'h01);
        bus(1'b1, 8'h91, 8'h00);
        repeat (3) @(posedge mclk_i);
        chk("irq", {7'h00, irq_o}, 8'h00);
        xpin <= 2'b11;
        bus(1'b1, 8'h91, 8'h0c);
        bus(1'b1, 8'h90, 8'hff);
        rdchk(8'h90, 8'h00);
        repeat (3) @(posedge mclk_i);
        chk("irq", {7'h00, irq_o}, 8'h00);
        finish_test();
    end
endmodule
bind dtc_top dtc_checker i_chk (.mclk_i, .reset_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o,
    .ext_irq0_pin_i, .ext_irq1_pin_i, .irq_o);
